//--- verilog/timer16_pwm.sv
// 16-bit timer with fast and phase correct PWM behind an AXI4-Lite slave
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module timer16_pwm #(
    parameter int NUM_CH = 2,
    parameter int ADDR_W = 8
) (
    // Clock and synchronous reset
    input wire logic clk,
    input wire logic rst_n,
    // Prescaler clock enable
    input wire logic timer_tick,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Waveform pins
    output logic [NUM_CH-1:0] wave_pin,
    output logic [NUM_CH-1:0] wave_pin_oe_n
);

    // Refuse shapes the map cannot hold, at elaboration rather than at run time
    if (NUM_CH < 1 || NUM_CH > timer16_pwm_pkg::MAX_CH || ADDR_W < 8) begin : g_bad_shape
        $error("timer16_pwm: unsupported NUM_CH or ADDR_W");
    end

    // Merge byte lanes 0 and 1 of a bus write into a 16-bit value
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] v;
        v = old;
        for (int b = 0; b < 2; b++) begin
            if (s[b]) begin
                v[8*b+:8] = d[8*b+:8];
            end
        end
        return v;
    endfunction : merge16

    // Software visible state
    timer16_pwm_pkg::ctrl_t ctrl; // Mode, output modes, pin directions
    logic [15:0] count; // Running count value
    logic up; // Counting direction, phase correct only
    logic [15:0] capt; // Capture value, also a TOP source
    logic ovf_flag; // Overflow flag
    logic capt_flag; // Capture flag
    logic [NUM_CH-1:0] match_vec; // Per channel compare match flags
    logic [NUM_CH-1:0][15:0] cmp_buf_all; // Buffered compare values
    logic [NUM_CH-1:0][15:0] cmp_act_all; // Active compare values

    // Bus write side holding registers
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Mode decode
    wire logic [3:0] mode = ctrl.wave_gen_mode;
    wire logic is_fast = mode == timer16_pwm_pkg::WGM_FAST8 ||
        mode == timer16_pwm_pkg::WGM_FAST9 || mode == timer16_pwm_pkg::WGM_FAST10 ||
        mode == timer16_pwm_pkg::WGM_FAST_CAPT || mode == timer16_pwm_pkg::WGM_FAST_CMPA;
    wire logic is_pc = mode == timer16_pwm_pkg::WGM_PC8 ||
        mode == timer16_pwm_pkg::WGM_PC9 || mode == timer16_pwm_pkg::WGM_PC10 ||
        mode == timer16_pwm_pkg::WGM_PC_CAPT || mode == timer16_pwm_pkg::WGM_PC_CMPA;
    wire logic pwm = is_fast || is_pc;
    wire logic top_capt = mode == timer16_pwm_pkg::WGM_FAST_CAPT ||
        mode == timer16_pwm_pkg::WGM_PC_CAPT;
    wire logic top_cmpa = mode == timer16_pwm_pkg::WGM_FAST_CMPA ||
        mode == timer16_pwm_pkg::WGM_PC_CMPA;
    wire logic top_fixed = pwm && !top_capt && !top_cmpa;

    // Fixed TOP by resolution; outside PWM the counter simply wraps at MAX
    wire logic [15:0] fix_top =
        (mode == timer16_pwm_pkg::WGM_FAST8 || mode == timer16_pwm_pkg::WGM_PC8) ?
            timer16_pwm_pkg::TOP_8 :
        (mode == timer16_pwm_pkg::WGM_FAST9 || mode == timer16_pwm_pkg::WGM_PC9) ?
            timer16_pwm_pkg::TOP_9 :
        (mode == timer16_pwm_pkg::WGM_FAST10 || mode == timer16_pwm_pkg::WGM_PC10) ?
            timer16_pwm_pkg::TOP_10 : timer16_pwm_pkg::MAX;
    // Capture TOP is taken live with no buffer, compare A TOP from the active copy
    wire logic [15:0] top_val = top_capt ? capt :
        top_cmpa ? cmp_act_all[0] : fix_top;
    wire logic at_top = count == top_val;
    wire logic at_bottom = count == timer16_pwm_pkg::BOTTOM;

    // Direction of the step taken this tick; BOTTOM always turns up, TOP down
    wire logic step_up = at_bottom ? 1'b1 : (at_top ? 1'b0 : up);
    // Buffer reload point, TOP in both PWM modes
    wire logic reload = timer_tick && pwm && at_top;

    // Next count: single slope clears after TOP, dual slope turns at both ends.
    // Counting up, a count above a freshly lowered capture TOP runs on through MAX and wraps.
    wire logic [15:0] next_count = is_pc ?
        (step_up ? count + timer16_pwm_pkg::COUNT_STEP :
                   count - timer16_pwm_pkg::COUNT_STEP) :
        ((is_fast && at_top) ? timer16_pwm_pkg::BOTTOM :
                               count + timer16_pwm_pkg::COUNT_STEP);

    // Flag events
    wire logic ovf_set = timer_tick && ((is_fast && at_top) || (is_pc && at_bottom) ||
        (!pwm && count == timer16_pwm_pkg::MAX));
    wire logic capt_set = reload && top_capt;

    // Register write decode
    wire logic do_write = aw_full && w_full && !bvalid;
    wire logic wr_ctrl = do_write && aw_addr == timer16_pwm_pkg::OFF_CTRL;
    wire logic wr_count = do_write && aw_addr == timer16_pwm_pkg::OFF_COUNT;
    wire logic wr_capt = do_write && aw_addr == timer16_pwm_pkg::OFF_CAPT;
    wire logic wr_flags = do_write && aw_addr == timer16_pwm_pkg::OFF_FLAGS && w_strb[0];
    wire logic [NUM_CH+1:0] clr = wr_flags ? w_data[NUM_CH+1:0] : '0;
    wire logic [15:0] ctrl_m = merge16(16'(ctrl), w_data, w_strb);
    logic wr_hit; // Write address maps to a register
    logic [31:0] rd_word; // Read mux result
    logic rd_hit; // Read address maps to a register

    // Hit detection and read mux
    always_comb begin
        wr_hit = aw_addr == timer16_pwm_pkg::OFF_CTRL || aw_addr == timer16_pwm_pkg::OFF_COUNT ||
            aw_addr == timer16_pwm_pkg::OFF_CAPT || aw_addr == timer16_pwm_pkg::OFF_FLAGS;
        rd_hit = 1'b1;
        rd_word = '0;
        unique case (araddr[7:0])
            timer16_pwm_pkg::OFF_CTRL: rd_word = 32'(ctrl);
            timer16_pwm_pkg::OFF_COUNT: rd_word = 32'(count);
            timer16_pwm_pkg::OFF_CAPT: rd_word = 32'(capt);
            timer16_pwm_pkg::OFF_FLAGS: rd_word = 32'({match_vec, capt_flag, ovf_flag});
            default: rd_hit = 1'b0;
        endcase
        // Compare registers read back the buffered value
        for (int i = 0; i < NUM_CH; i++) begin
            if (aw_addr == timer16_pwm_pkg::OFF_CMP[i]) begin
                wr_hit = 1'b1;
            end
            if (araddr[7:0] == timer16_pwm_pkg::OFF_CMP[i]) begin
                rd_hit = 1'b1;
                rd_word = 32'(cmp_buf_all[i]);
            end
        end
    end

    // Next values of the bus handshake state
    wire logic aw_hs = awvalid && awready;
    wire logic w_hs = wvalid && wready;
    wire logic ar_hs = arvalid && arready;
    wire logic next_aw_full = (aw_full || aw_hs) && !do_write;
    wire logic next_w_full = (w_full || w_hs) && !do_write;
    wire logic next_bvalid = do_write || (bvalid && !bready);
    wire logic next_rvalid = ar_hs || (rvalid && !rready);

    // Write channel: address and data land in either order, one write in flight
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= timer16_pwm_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_addr <= awaddr[7:0];
            end
            if (w_hs) begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
            // Unmapped or unaligned addresses answer with a slave error
            if (do_write) begin
                bresp <= wr_hit ? timer16_pwm_pkg::RESP_OKAY : timer16_pwm_pkg::RESP_SLVERR;
            end
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            bvalid <= next_bvalid;
            awready <= !next_aw_full && !next_bvalid;
            wready <= !next_w_full && !next_bvalid;
        end
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= timer16_pwm_pkg::RESP_OKAY;
        end else begin
            if (ar_hs) begin
                rdata <= rd_word;
                rresp <= rd_hit ? timer16_pwm_pkg::RESP_OKAY : timer16_pwm_pkg::RESP_SLVERR;
            end
            rvalid <= next_rvalid;
            arready <= !next_rvalid;
        end
    end

    // Control and capture registers; capture writes take effect at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= '0;
            capt <= timer16_pwm_pkg::BOTTOM;
        end else begin
            if (wr_ctrl) begin
                ctrl <= timer16_pwm_pkg::ctrl_t'(ctrl_m[timer16_pwm_pkg::CTRL_W-1:0]);
            end
            if (wr_capt) begin
                capt <= merge16(capt, w_data, w_strb);
            end
        end
    end

    // Counter; a software write wins over the tick in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= timer16_pwm_pkg::BOTTOM;
            up <= 1'b1;
        end else if (wr_count) begin
            count <= merge16(count, w_data, w_strb);
        end else if (timer_tick) begin
            count <= next_count;
            up <= is_pc ? step_up : 1'b1;
        end
    end

    // Shared flags; a set in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovf_flag <= 1'b0;
            capt_flag <= 1'b0;
        end else begin
            ovf_flag <= ovf_set || (ovf_flag && !clr[timer16_pwm_pkg::FLG_OVF]);
            capt_flag <= capt_set || (capt_flag && !clr[timer16_pwm_pkg::FLG_CAPT]);
        end
    end

    // Per channel compare, buffer, waveform and pin logic
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [15:0] cmp_buf; // Written by software
        logic [15:0] cmp_act; // Compared against the count
        logic wave; // Generated level
        logic match_flag; // Compare match flag
        wire logic wr = do_write && aw_addr == timer16_pwm_pkg::OFF_CMP[i];
        // Unused upper bits vanish on write when TOP is fixed
        wire logic [15:0] wval = merge16(cmp_buf, w_data, w_strb) &
            (top_fixed ? fix_top : timer16_pwm_pkg::MAX);
        // Count never reaches a compare above TOP, so that channel stays quiet
        wire logic match = count == cmp_act;
        wire logic [1:0] om = ctrl.out_mode[i];
        wire logic inv = om == timer16_pwm_pkg::COM_INV;
        wire logic pol = om == timer16_pwm_pkg::COM_NONINV || inv;
        wire logic tog = om == timer16_pwm_pkg::COM_TOGGLE && i == 0;
        // Fast: in set and clear modes TOP action beats the match, so compare equal TOP holds level; toggle mode toggles on channel A only
        wire logic fast_wave = !pol ? (tog && match ? !wave : wave) :
            at_top ? !inv : (match ? inv : wave);
        // Dual slope: clear rising, set falling; inverted mode swaps
        wire logic pc_wave = (pol && match) ? (step_up ? inv : !inv) : wave;

        // Buffer and active compare; outside PWM writes go straight through
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cmp_buf <= timer16_pwm_pkg::BOTTOM;
                cmp_act <= timer16_pwm_pkg::BOTTOM;
            end else begin
                if (wr) begin
                    cmp_buf <= wval;
                end
                if (reload) begin
                    cmp_act <= cmp_buf;
                end else if (wr && !pwm) begin
                    cmp_act <= wval;
                end
            end
        end

        // Waveform level, flag and pin driver
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                wave <= 1'b0;
                match_flag <= 1'b0;
                wave_pin[i] <= 1'b0;
                wave_pin_oe_n[i] <= 1'b1;
            end else begin
                if (timer_tick && is_fast) begin
                    wave <= fast_wave;
                end else if (timer_tick && is_pc) begin
                    wave <= pc_wave;
                end
                match_flag <= (timer_tick && pwm && match) ||
                    (match_flag && !clr[timer16_pwm_pkg::FLG_MATCH+i]);
                wave_pin[i] <= wave;
                wave_pin_oe_n[i] <= !(ctrl.dir[i] && om != timer16_pwm_pkg::COM_OFF);
            end
        end

        assign cmp_buf_all[i] = cmp_buf;
        assign cmp_act_all[i] = cmp_act;
        assign match_vec[i] = match_flag;
    end

    // Checks on channel A and the counter
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_fast_ovf_top: assert property (
        timer_tick && is_fast && at_top |=> ovf_flag)
        else $error("overflow flag missing after fast TOP");
    a_top_flag_pair: assert property (
        timer_tick && is_fast && at_top && top_capt |=> capt_flag && ovf_flag)
        else $error("capture flag not set with overflow");
    a_mask_fixed: assert property (
        g_ch[0].wr && top_fixed && !wr_ctrl |=>
        (g_ch[0].cmp_buf & ~fix_top) == timer16_pwm_pkg::BOTTOM)
        else $error("compare upper bits not masked");
    a_capt_wrap: assert property (
        timer_tick && is_fast && !wr_count && count > top_val |=>
        count == $past(count) + timer16_pwm_pkg::COUNT_STEP)
        else $error("count above TOP did not run on");
    a_buf_load: assert property (
        reload && !wr_count |=> g_ch[0].cmp_act == $past(g_ch[0].cmp_buf))
        else $error("active compare not loaded at TOP");
    a_fast_top_lvl: assert property (
        timer_tick && is_fast && at_top && g_ch[0].om == timer16_pwm_pkg::COM_NONINV
        |=> g_ch[0].wave ##1 wave_pin[0])
        else $error("non-inverted level not set at TOP");
    a_pin_gate: assert property (
        !wave_pin_oe_n[0] |-> $past(ctrl.dir[0]))
        else $error("pin driven without output direction");
    a_pc_turn: assert property (
        timer_tick && is_pc && at_top && !wr_count |=>
        !up && count == $past(count) - timer16_pwm_pkg::COUNT_STEP)
        else $error("phase correct did not turn at TOP");
    a_pc_bottom: assert property (
        timer_tick && is_pc && at_bottom && !wr_count |=> ovf_flag && up)
        else $error("phase correct BOTTOM not flagged");
    a_tick_hold: assert property (
        !timer_tick && !wr_count |=> $stable(count))
        else $error("count moved without tick");

endmodule : timer16_pwm

//--- verilog/timer16_pwm_pkg.sv
// Constants, register map and carrier types of the 16-bit PWM timer
package timer16_pwm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_CMP_A = 8'h08;
    localparam logic [7:0] OFF_CMP_B = 8'h0C;
    localparam logic [7:0] OFF_CAPT = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    // Most channels the map has room for
    localparam int MAX_CH = 2;
    localparam logic [7:0] OFF_CMP [MAX_CH] = '{OFF_CMP_A, OFF_CMP_B};
    // Flag register bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_CAPT = 1;
    localparam int FLG_MATCH = 2;
    // Waveform generation modes in scope
    localparam logic [3:0] WGM_PC8 = 4'h1;
    localparam logic [3:0] WGM_PC9 = 4'h2;
    localparam logic [3:0] WGM_PC10 = 4'h3;
    localparam logic [3:0] WGM_FAST8 = 4'h5;
    localparam logic [3:0] WGM_FAST9 = 4'h6;
    localparam logic [3:0] WGM_FAST10 = 4'h7;
    localparam logic [3:0] WGM_PC_CAPT = 4'hA;
    localparam logic [3:0] WGM_PC_CMPA = 4'hB;
    localparam logic [3:0] WGM_FAST_CAPT = 4'hE;
    localparam logic [3:0] WGM_FAST_CMPA = 4'hF;
    // Output modes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;
    // Counter values
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8 = 16'h00FF;
    localparam logic [15:0] TOP_9 = 16'h01FF;
    localparam logic [15:0] TOP_10 = 16'h03FF;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Control register layout, top bit downward
    localparam int CTRL_W = 10;
    typedef struct packed {
        logic [MAX_CH-1:0] dir;
        logic [MAX_CH-1:0][1:0] out_mode;
        logic [3:0] wave_gen_mode;
    } ctrl_t;
endpackage : timer16_pwm_pkg

//--- sim/pwm_load.sv
// Load model on one PWM pin: resolves the line and times its pulses
`timescale 1ns/1ps
module pwm_load (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin from the timer
    input wire logic pin,
    input wire logic oe_n,
    // Line level and pulse timing in clk cycles
    output logic line,
    output int per,
    output int high,
    output int edges
);
    logic prev; // Line one clk ago
    int since; // Clocks since last rise
    // Pull-down holds the line low while the pin floats
    assign line = oe_n ? 1'b0 : pin;
    // Pulse timing, measured rise to rise and rise to fall
    always @(posedge clk) begin
        prev <= line;
        if (!rst_n) begin
            since <= 0;
            edges <= 0;
        end else begin
            since <= (line && !prev) ? 1 : since + 1;
            if (line && !prev) per <= since;
            if (!line && prev) high <= since;
            if (line != prev) edges <= edges + 1;
        end
    end
endmodule : pwm_load

//--- sim/timer16_pwm_pwm_tb_top.sv
// Self-checking bench of the PWM timer with two pin loads
`timescale 1ns/1ps
module timer16_pwm_waveform_modes_tb_top;
    logic clk, rst_n, timer_tick, tick_en; // Clock, reset, prescaler
    logic awvalid, wvalid, bready, arvalid, rready; // Bus strobes
    logic [7:0] awaddr, araddr; // Bus addresses
    logic [31:0] wdata; // Write data
    logic [3:0] wstrb; // Byte lanes
    logic [1:0] last_resp; // Response of the last access
    wire awready, wready, bvalid, arready, rvalid; // Slave answers
    wire [1:0] bresp, rresp; // Response codes
    wire [31:0] rdata; // Read data
    wire [1:0] wave_pin, wave_pin_oe_n; // Waveform pins
    logic [1:0] line; // Resolved pin lines
    int per[2], high[2], edges[2]; // Load measurements
    int failures, comparisons, tdiv, tc; // Counters, prescale
    timer16_pwm i_dut (.clk(clk), .rst_n(rst_n), .timer_tick(timer_tick),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .wave_pin(wave_pin), .wave_pin_oe_n(wave_pin_oe_n));
    // One load per channel
    for (genvar i = 0; i < 2; i++) begin : g_load
        pwm_load i_load (.clk(clk), .rst_n(rst_n), .pin(wave_pin[i]),
            .oe_n(wave_pin_oe_n[i]), .line(line[i]), .per(per[i]),
            .high(high[i]), .edges(edges[i]));
    end
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Prescaler: one tick every tdiv clocks
    always @(posedge clk) begin
        tc <= (tc >= tdiv - 1) ? 0 : tc + 1;
        timer_tick <= tick_en && (tc == tdiv - 1);
    end
    // Verdict and end of run
    task automatic end_of_test;
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // Compare and report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                last_resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr
    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                last_resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd
    // Stop timer, load compares in normal mode so they land directly, start
    task automatic setup(input logic [3:0] m, input logic [1:0] oa, input logic [1:0] ob,
        input logic [1:0] dr, input logic [15:0] ca, input logic [15:0] cb, input int div);
        timer16_pwm_pkg::ctrl_t c;
        c.wave_gen_mode = m;
        c.out_mode[0] = oa;
        c.out_mode[1] = ob;
        c.dir = dr;
        tick_en <= 1'b0;
        wr(timer16_pwm_pkg::OFF_CTRL, 32'h0);
        wr(timer16_pwm_pkg::OFF_CMP_A, {16'h0, ca});
        wr(timer16_pwm_pkg::OFF_CMP_B, {16'h0, cb});
        wr(timer16_pwm_pkg::OFF_CAPT, {16'h0, ca});
        wr(timer16_pwm_pkg::OFF_COUNT, 32'h0);
        wr(timer16_pwm_pkg::OFF_CTRL, {22'h0, c});
        wr(timer16_pwm_pkg::OFF_FLAGS, 32'hF);
        tdiv = div;
        tick_en <= 1'b1;
    endtask : setup
    // Let a few periods pass, then judge the last pulse
    task automatic meas(input int ch, input int p, input int h);
        repeat (3 * p + 20) @(posedge clk);
        chk("pulse period", p, per[ch]);
        chk("pulse high", h, high[ch]);
    endtask : meas
    // Fast PWM, TOP from compare A, toggle, flags, tick gating, buffering
    task automatic t_fast;
        logic [31:0] d;
        setup(4'hF, 2'h1, 2'h2, 2'b11, 16'h0007, 16'h0003, 1);
        meas(1, 8, 4);
        meas(0, 16, 8);
        tick_en <= 1'b0;
        rd(timer16_pwm_pkg::OFF_FLAGS, d);
        chk("flags", 32'h5, d & 32'h7);
        wr(timer16_pwm_pkg::OFF_COUNT, 32'h5);
        repeat (10) @(posedge clk);
        rd(timer16_pwm_pkg::OFF_COUNT, d);
        chk("stopped count", 32'h5, d);
        // Lower TOP below count: only a buffered write avoids the long wrap
        wr(timer16_pwm_pkg::OFF_CMP_A, 32'h3);
        tick_en <= 1'b1;
        meas(0, 8, 4);
    endtask : t_fast
    // Inverted fast PWM through the prescaler, channel A pin released
    task automatic t_pre;
        setup(4'hF, 2'h2, 2'h3, 2'b10, 16'h0007, 16'h0001, 4);
        meas(1, 32, 24);
        chk("pin A enable", 1'b1, wave_pin_oe_n[0]);
        chk("pin A line", 1'b0, line[0]);
        chk("pin B enable", 1'b0, wave_pin_oe_n[1]);
    endtask : t_pre
    // Phase correct, TOP from compare A, both polarities, flags
    task automatic t_phase;
        logic [31:0] d;
        for (int i = 2; i < 4; i++) begin
            setup(4'hB, 2'h0, 2'(i), 2'b10, 16'h0006, 16'h0002, 1);
            meas(1, 12, i == 2 ? 4 : 8);
        end
        tick_en <= 1'b0;
        rd(timer16_pwm_pkg::OFF_FLAGS, d);
        chk("flags", 32'h5, d & 32'h7);
    endtask : t_phase
    // Extreme compare values: steady levels, compare above TOP, the one-tick spike
    task automatic t_ext;
        int e;
        for (int i = 0; i < 4; i++) begin
            setup(i < 2 ? 4'hB : 4'hF, 2'h0, 2'h2, 2'b10, i < 2 ? 16'h0006 : 16'h0007,
                i == 0 ? 16'h0000 : (i == 1 ? 16'h0006 : 16'h0007 + 16'(i - 2)), 1);
            repeat (30) @(posedge clk);
            e = edges[1];
            repeat (40) @(posedge clk);
            chk("edge count", e, edges[1]);
            chk("steady level", i != 0, line[1]);
        end
        setup(4'hF, 2'h0, 2'h2, 2'b10, 16'h0007, 16'h0000, 1);
        meas(1, 8, 1);
    endtask : t_ext
    // Fixed and capture TOP in both slopes; capture flag at TOP
    task automatic t_tops;
        logic [31:0] d;
        int t, cb;
        for (int i = 0; i < 4; i++) begin
            t = (i >= 2) ? 9 : 255;
            cb = (i >= 2) ? 3 : 16;
            setup(i == 0 ? 4'h5 : i == 1 ? 4'h1 : i == 2 ? 4'hE : 4'hA, 2'h0, 2'h2,
                2'b10, 16'(t), 16'(cb), 1);
            meas(1, i % 2 ? 2 * t : t + 1, i % 2 ? 2 * cb : cb + 1);
            if (i >= 2) begin
                tick_en <= 1'b0;
                rd(timer16_pwm_pkg::OFF_FLAGS, d);
                chk("capture flag", 32'h2, d & 32'h2);
            end
            // Capture TOP lowered under the count takes effect at once and forces a wrap
            if (i == 2) begin
                wr(timer16_pwm_pkg::OFF_COUNT, 32'h0000FFFC);
                wr(timer16_pwm_pkg::OFF_CAPT, 32'h3);
                tick_en <= 1'b1;
                repeat (9) @(posedge clk);
                tick_en <= 1'b0;
                rd(timer16_pwm_pkg::OFF_COUNT, d);
                chk("wrapped count", 32'h1, d);
            end
        end
    endtask : t_tops
    // Fixed TOP masks compare writes; unmapped read refused
    task automatic t_fixed;
        logic [31:0] d;
        tick_en <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(timer16_pwm_pkg::OFF_CTRL, 32'(i < 3 ? 5 + i : i - 2));
            wr(i % 2 ? timer16_pwm_pkg::OFF_CMP_B : timer16_pwm_pkg::OFF_CMP_A, 32'h0000FFFF);
            chk("write response", timer16_pwm_pkg::RESP_OKAY, last_resp);
            rd(i % 2 ? timer16_pwm_pkg::OFF_CMP_B : timer16_pwm_pkg::OFF_CMP_A, d);
            chk("masked compare", (32'h100 << (i % 3)) - 1, d);
        end
        wr(8'h18, 32'h1);
        chk("unmapped write", timer16_pwm_pkg::RESP_SLVERR, last_resp);
        rd(8'h18, d);
        chk("unmapped response", timer16_pwm_pkg::RESP_SLVERR, last_resp);
        chk("unmapped data", 32'h0, d);
    endtask : t_fixed
    // Main sequence
    initial begin
        {rst_n, tick_en, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {failures, comparisons} = '0;
        tdiv = 1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_fast();
        t_pre();
        t_phase();
        t_ext();
        t_tops();
        t_fixed();
        end_of_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule : timer16_pwm_waveform_modes_tb_top
